// File: logic/tmr_pkg.sv
package tmr_pkg;
  // -----------------------------------------------------------------
  // Register map, 32-bit Avalon-MM word addresses (byte offsets).
  // -----------------------------------------------------------------
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] modulo_off = 8'h04;
  localparam logic [7:0] cnt_high_off = 8'h08;
  localparam logic [7:0] cnt_low_off = 8'h0c;
  localparam logic [7:0] status_off = 8'h10;
  localparam logic [7:0] ch_base_off = 8'h20;
  localparam logic [7:0] ch_stride = 8'h08;
  localparam int num_ch = 2;
  // Control fields.
  localparam int ctrl_psc_lsb = 0;
  localparam int ctrl_cas_bit = 3;
  localparam int ctrl_en_bit = 4;
  // Channel control fields.
  localparam int chc_edge_lsb = 0;
  localparam int chc_mode_lsb = 2;
  localparam int stat_ovf_bit = 0;
  localparam int stat_ch_lsb = 1;
  localparam logic [15:0] modulo_rst = 16'hffff;
  localparam logic [31:0] unmapped_val = 32'h00000000;
  typedef enum logic [1:0] {
    mode_capture, mode_compare, mode_pwm, mode_off
  } ch_mode_t;
endpackage

// File: logic/tmr_ch_if.sv
`timescale 1ns/1ps
interface tmr_ch_if;
  logic [15:0] count;
  logic center;
  logic tick;
  logic [1:0] mode;
  logic [1:0] edge_sel;
  logic [15:0] value;
  logic pin_in;
  logic event_hit;
  modport top(output count, center, tick, mode, edge_sel, value, pin_in,
              input event_hit);
  modport chan(input count, center, tick, mode, edge_sel, value, pin_in,
               output event_hit);
endinterface

// File: logic/tmr_channel.sv
`timescale 1ns/1ps
module tmr_channel (
  input wire mclk,
  input wire nrst,
  input wire ce,
  tmr_ch_if.chan ch
);
  logic pin_prev_ff;
  logic nxt_pin_prev;
  logic rise;
  logic fall;

  // Edge history; the pin is taken as synchronous already.
  always_comb begin
    nxt_pin_prev = ch.pin_in;
    rise = ch.pin_in & ~pin_prev_ff;
    fall = ~ch.pin_in & pin_prev_ff;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_prev_ff <= 1'b0;
    end else if (ce) begin
      pin_prev_ff <= nxt_pin_prev;
    end
  end

  // Event per mode; matches count only on a counter tick.
  always_comb begin
    ch.event_hit = 1'b0;
    case (ch.mode)
      2'(tmr_pkg::mode_capture): begin
        ch.event_hit = (ch.edge_sel[0] & rise) |
                       (ch.edge_sel[1] & fall);
      end
      2'(tmr_pkg::mode_compare): begin
        ch.event_hit = ch.tick & (ch.count == ch.value);
      end
      2'(tmr_pkg::mode_pwm): begin
        // Center mode passes the value going up and going down.
        ch.event_hit = ch.tick & (ch.count == ch.value);
        // Both passes hit in center mode.
      end
      default: begin
        ch.event_hit = 1'b0;
      end
    endcase
  end
endmodule // tmr_channel

// File: logic/timer_channel_event_flags.sv
`timescale 1ns/1ps
module timer_channel_event_flags (
  input wire mclk,
  input wire nrst,
  input wire ce,
  input wire background_debug_mode,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire [1:0] cap_in,
  output logic [1:0] pwm_out
);
  // ---------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------
  logic [4:0] ctrl_ff, nxt_ctrl;
  logic [15:0] modulo_ff, nxt_modulo;
  logic [15:0] count_ff, nxt_count;
  logic [6:0] psc_ff, nxt_psc;
  logic down_ff, nxt_down;
  logic ovf_ff, nxt_ovf;
  logic ovf_armed_ff, nxt_ovf_armed;
  logic [3:0] chc_ff [2], nxt_chc [2];
  logic [15:0] chv_ff [2], nxt_chv [2];
  logic [1:0] flag_ff, nxt_flag;
  logic [1:0] armed_ff, nxt_armed;
  logic [1:0] pwm_ff, nxt_pwm;
  logic [31:0] rdata_ff, nxt_rdata;
  logic done_ff, nxt_done;
  logic [1:0] hit;
  logic tick;
  logic center;
  logic [6:0] psc_lim;
  logic req;
  logic [2:0] idx;
  logic is_ch;
  logic ch_sel;
  logic ch_val;
  logic wr_take;

  assign center = ctrl_ff[tmr_pkg::ctrl_cas_bit];
  assign psc_lim = 7'((8'h01 << ctrl_ff[2:0]) - 8'h01);
  // Counter frozen during debug so reads see a stable value.
  assign tick = ctrl_ff[tmr_pkg::ctrl_en_bit] & ~background_debug_mode &
                (psc_ff == psc_lim);
  assign req = (avs_read | avs_write) & ~done_ff;
  // A write lands only on the edge where waitrequest is seen low.
  assign wr_take = avs_write & done_ff;
  assign is_ch = (avs_address >= tmr_pkg::ch_base_off) &&
                 (avs_address < 8'(tmr_pkg::ch_base_off + 2 * tmr_pkg::ch_stride));
  assign idx = 3'((avs_address - tmr_pkg::ch_base_off) >> 2);
  assign ch_sel = idx[1];
  assign ch_val = idx[0];

  // ---------------------------------------------------------------
  // Channels.
  // ---------------------------------------------------------------
  for (genvar i = 0; i < tmr_pkg::num_ch; i++) begin : g_ch
    tmr_ch_if chi ();
    assign chi.count = count_ff;
    assign chi.center = center;
    assign chi.tick = tick;
    assign chi.mode = chc_ff[i][3:2];
    assign chi.edge_sel = chc_ff[i][1:0];
    assign chi.value = chv_ff[i];
    assign chi.pin_in = cap_in[i];
    assign hit[i] = chi.event_hit;
    tmr_channel u_ch (
      .mclk(mclk),
      .nrst(nrst),
      .ce(ce),
      .ch(chi.chan)
    );
  end

  // Counter, flags, bus. One answer cycle: waitrequest drops the
  // cycle after the request appears, then a done cycle blocks reuse.
  // Reads are captured on the first edge, writes on the answer edge,
  // so a write never takes effect while waitrequest is still high.
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_modulo = modulo_ff;
    nxt_count = count_ff;
    nxt_psc = psc_ff;
    nxt_down = down_ff;
    nxt_ovf = ovf_ff;
    nxt_ovf_armed = ovf_armed_ff;
    nxt_chc = chc_ff;
    nxt_chv = chv_ff;
    nxt_flag = flag_ff;
    nxt_armed = armed_ff;
    nxt_pwm = pwm_ff;
    nxt_rdata = rdata_ff;
    nxt_done = req;
    if (ctrl_ff[tmr_pkg::ctrl_en_bit] && !background_debug_mode) begin
      nxt_psc = tick ? 7'h00 : 7'(psc_ff + 7'h01);
    end
    if (tick) begin
      if (!center) begin
        nxt_down = 1'b0;
        if (count_ff >= modulo_ff) begin
          nxt_count = 16'h0000;
          nxt_ovf = 1'b1;
        end else begin
          nxt_count = count_ff + 16'h0001;
        end
      end else if (!down_ff) begin
        if (count_ff >= modulo_ff) begin
          nxt_down = 1'b1;
          nxt_ovf = 1'b1;
          nxt_count = count_ff - 16'h0001;
        end else begin
          nxt_count = count_ff + 16'h0001;
        end
      end else if (count_ff <= 16'h0001) begin
        nxt_down = 1'b0;
        nxt_count = 16'h0000;
      end else begin
        nxt_count = count_ff - 16'h0001;
      end
      for (int i = 0; i < 2; i++) begin
        if (chc_ff[i][3:2] == 2'(tmr_pkg::mode_pwm)) begin
          if (count_ff == chv_ff[i]) begin
            nxt_pwm[i] = center ? ~pwm_ff[i] : 1'b0;
          end else if (!center && count_ff == 16'h0000) begin
            nxt_pwm[i] = 1'b1;
          end
        end else if (chc_ff[i][3:2] == 2'(tmr_pkg::mode_compare) &&
                     count_ff == chv_ff[i]) begin
          nxt_pwm[i] = ~pwm_ff[i];
        end
      end
    end
    if (req && avs_read) begin
      nxt_rdata = tmr_pkg::unmapped_val;
      if (avs_address == tmr_pkg::ctrl_off) begin
        nxt_rdata = {27'h0, ctrl_ff};
      end else if (avs_address == tmr_pkg::modulo_off) begin
        nxt_rdata = {16'h0000, modulo_ff};
      end else if (avs_address == tmr_pkg::cnt_high_off) begin
        nxt_rdata = {24'h000000, count_ff[15:8]};
      end else if (avs_address == tmr_pkg::cnt_low_off) begin
        nxt_rdata = {24'h000000, count_ff[7:0]};
      end else if (avs_address == tmr_pkg::status_off) begin
        nxt_rdata = {29'h0, flag_ff, ovf_ff};
        nxt_armed = flag_ff;
        nxt_ovf_armed = ovf_ff;
      end else if (is_ch) begin
        nxt_rdata = ch_val ? {16'h0000, chv_ff[ch_sel]} :
                             {28'h0000000, chc_ff[ch_sel]};
      end
    end
    if (wr_take) begin
      if (avs_address == tmr_pkg::ctrl_off) begin
        nxt_ctrl = avs_writedata[4:0];
      end else if (avs_address == tmr_pkg::modulo_off) begin
        nxt_modulo = avs_writedata[15:0];
      end else if (avs_address == tmr_pkg::cnt_high_off ||
                   avs_address == tmr_pkg::cnt_low_off) begin
        nxt_count = 16'h0000;
        nxt_psc = 7'h00;
        nxt_down = 1'b0;
      end else if (avs_address == tmr_pkg::status_off) begin
        for (int i = 0; i < 2; i++) begin
          if (armed_ff[i] && !avs_writedata[tmr_pkg::stat_ch_lsb + i]) begin
            nxt_flag[i] = 1'b0;
          end
        end
        if (ovf_armed_ff && !avs_writedata[tmr_pkg::stat_ovf_bit]) begin
          nxt_ovf = 1'b0;
        end
        nxt_armed = 2'b00;
        nxt_ovf_armed = 1'b0;
      end else if (is_ch) begin
        if (ch_val) begin
          nxt_chv[ch_sel] = avs_writedata[15:0];
        end else begin
          nxt_chc[ch_sel] = avs_writedata[3:0];
        end
      end
    end
    // Set wins over a clear in the same cycle.
    nxt_flag = nxt_flag | hit;
    if (tick && !center && count_ff >= modulo_ff) begin
      nxt_ovf = 1'b1;
    end
    if (tick && center && !down_ff && count_ff >= modulo_ff) begin
      nxt_ovf = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= 5'h00;
      modulo_ff <= tmr_pkg::modulo_rst;
      count_ff <= 16'h0000;
      psc_ff <= 7'h00;
      down_ff <= 1'b0;
      ovf_ff <= 1'b0;
      ovf_armed_ff <= 1'b0;
      chc_ff <= '{default: 4'hc};
      chv_ff <= '{default: 16'h0000};
      flag_ff <= 2'b00;
      armed_ff <= 2'b00;
      pwm_ff <= 2'b00;
      rdata_ff <= 32'h00000000;
      done_ff <= 1'b0;
    end else if (ce) begin
      ctrl_ff <= nxt_ctrl;
      modulo_ff <= nxt_modulo;
      count_ff <= nxt_count;
      psc_ff <= nxt_psc;
      down_ff <= nxt_down;
      ovf_ff <= nxt_ovf;
      ovf_armed_ff <= nxt_ovf_armed;
      chc_ff <= nxt_chc;
      chv_ff <= nxt_chv;
      flag_ff <= nxt_flag;
      armed_ff <= nxt_armed;
      pwm_ff <= nxt_pwm;
      rdata_ff <= nxt_rdata;
      done_ff <= nxt_done;
    end
  end

  // Outputs straight from flip-flops; waitrequest low only in done cycle.
  always_comb begin
    avs_readdata = rdata_ff;
    avs_waitrequest = ~done_ff;
    pwm_out = pwm_ff;
  end
endmodule // timer_channel_event_flags

// File: tb/tmr_flag_assertions.sv
`timescale 1ns/1ps
// ------------------------------
// Bus and flag checks at the pins.
// ------------------------------
module tmr_flag_assertions (
  input wire mclk,
  input wire nrst,
  input wire ce,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  logic [2:0] seen_ff;
  logic [2:0] nxt_seen;
  logic st_rd;
  logic st_wr;
  // Flags seen set by the last status read, forgotten on a status write.
  assign st_rd = avs_read && !avs_waitrequest
    && avs_address == tmr_pkg::status_off;
  assign st_wr = avs_write && !avs_waitrequest
    && avs_address == tmr_pkg::status_off;
  always_comb begin
    nxt_seen = seen_ff;
    if (st_wr) begin
      nxt_seen = 3'h0;
    end else if (st_rd) begin
      nxt_seen = avs_readdata[2:0];
    end
  end
  // Registered so a write in the same cycle cannot hide a clear.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seen_ff <= 3'h0;
    end else begin
      seen_ff <= nxt_seen;
    end
  end
  sequence req_s;
    ce && (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence ans_s;
    !avs_waitrequest;
  endsequence
  chk_answer_next:
    assert property (req_s |=> ans_s) else $error("late bus answer");
  chk_no_spurious:
    assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  chk_wait_one:
    assert property (ans_s |=> avs_waitrequest) else $error("long answer");
  chk_unmapped_zero:
    assert property (avs_read && !avs_waitrequest && avs_address == 8'h40
      |-> avs_readdata == tmr_pkg::unmapped_val)
    else $error("unmapped read not zero");
  chk_status_upper:
    assert property (st_rd |-> avs_readdata[31:3] == 29'h0)
    else $error("status spare bits set");
  chk_chctrl_upper:
    assert property (avs_read && !avs_waitrequest
      && avs_address == tmr_pkg::ch_base_off |-> avs_readdata[31:4] == 28'h0)
    else $error("channel control spare bits set");
  chk_flag_sticky:
    assert property (st_rd |-> (avs_readdata[2:0] & seen_ff) == seen_ff)
    else $error("flag dropped without clear");
  chk_readdata_hold:
    assert property (!$past(avs_read) |-> $stable(avs_readdata))
    else $error("read data moved without read");
endmodule // tmr_flag_assertions

bind timer_channel_event_flags tmr_flag_assertions chk (.mclk, .nrst, .ce,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest);

// File: tb/cap_pin_model.sv
`timescale 1ns/1ps
// ------------------------------
// Outside world driving the capture pins.
// ------------------------------
module cap_pin_model (
  input wire mclk,
  input wire nrst,
  input wire [1:0] lvl,
  output logic [1:0] cap_in
);
  // Pins move just after an edge, like a synchronous source.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cap_in <= 2'h0;
    end else begin
      cap_in <= lvl;
    end
  end
endmodule // cap_pin_model

// File: tb/tb.sv
`timescale 1ns/1ps
// ------------------------------
// Self-checking bench.
// ------------------------------
module tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic dbg = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic wt;
  logic [1:0] lvl = 2'h0;
  logic [1:0] cap;
  logic [1:0] pw;
  logic [31:0] q;
  int fails = 0;
  int checks_done = 0;
  // Free-running 25 MHz clock.
  always #20 mclk = ~mclk;
  cap_pin_model pins (.mclk, .nrst, .lvl, .cap_in(cap));
  timer_channel_event_flags uut (.mclk, .nrst, .ce(1'b1),
    .background_debug_mode(dbg), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
    .avs_waitrequest(wt), .cap_in(cap), .pwm_out(pw));
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Request held until the rising edge where waitrequest is low; the
  // registered answer is read there, before the edge updates it.
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge mclk);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    @(posedge mclk);
    while (wt !== 1'b0) @(posedge mclk);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdc(input string what, input logic [7:0] a,
    input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, q & m, exp);
  endtask
  task automatic clr();
    bus(1'b0, tmr_pkg::status_off, 32'h0);
    bus(1'b1, tmr_pkg::status_off, 32'h0);
  endtask
  task automatic t_regs();
    rdc("modulo", tmr_pkg::modulo_off, 32'hffff, 32'h0000ffff);
    rdc("ch ctrl", tmr_pkg::ch_base_off, 32'hffffffff, 32'h0000000c);
    rdc("unmapped", 8'h40, 32'hffffffff, tmr_pkg::unmapped_val);
  endtask
  task automatic t_compare();
    bus(1'b1, tmr_pkg::modulo_off, 32'h20);
    bus(1'b1, 8'h24, 32'h5);
    bus(1'b1, 8'h20, 32'h4);
    bus(1'b1, tmr_pkg::ctrl_off, 32'h10);
    repeat (80) @(posedge mclk);
    bus(1'b1, tmr_pkg::ctrl_off, 32'h0);
    bus(1'b1, tmr_pkg::status_off, 32'h0);
    rdc("compare flag", tmr_pkg::status_off, 32'h2, 32'h2);
    bus(1'b1, tmr_pkg::status_off, 32'h0);
    rdc("flag cleared", tmr_pkg::status_off, 32'h2, 32'h0);
  endtask
  task automatic t_capture();
    bus(1'b1, 8'h20, 32'hc);
    for (int e = 0; e < 4; e++) begin
      bus(1'b1, 8'h28, 32'(e));
      clr();
      lvl <= 2'h2;
      repeat (6) @(posedge mclk);
      rdc("rise", tmr_pkg::status_off, 32'h4, {29'h0, e[0], 2'h0});
      clr();
      lvl <= 2'h0;
      repeat (6) @(posedge mclk);
      rdc("fall", tmr_pkg::status_off, 32'h4, {29'h0, e[1], 2'h0});
    end
  endtask
  // Centre mode, modulo 32, match at 8: up hit, turn at 32, down hit.
  task automatic t_center();
    bus(1'b1, 8'h28, 32'hc);
    bus(1'b1, 8'h24, 32'h8);
    bus(1'b1, 8'h20, 32'h8);
    bus(1'b1, tmr_pkg::cnt_low_off, 32'h0);
    clr();
    bus(1'b1, tmr_pkg::ctrl_off, 32'h18);
    repeat (12) @(posedge mclk);
    rdc("up match", tmr_pkg::status_off, 32'h3, 32'h2);
    bus(1'b1, tmr_pkg::status_off, 32'h0);
    repeat (18) @(posedge mclk);
    rdc("turn", tmr_pkg::status_off, 32'h3, 32'h1);
    repeat (20) @(posedge mclk);
    rdc("down match", tmr_pkg::status_off, 32'h2, 32'h2);
  endtask
  // Divide by 8, so a kept prescaler count would show within the read.
  task automatic t_counter();
    bus(1'b1, tmr_pkg::modulo_off, 32'hffff);
    bus(1'b1, tmr_pkg::ctrl_off, 32'h13);
    repeat (30) @(posedge mclk);
    bus(1'b1, tmr_pkg::cnt_high_off, 32'ha5);
    rdc("cleared", tmr_pkg::cnt_low_off, 32'hff, 32'h0);
    dbg <= 1'b1;
    bus(1'b1, tmr_pkg::cnt_low_off, 32'h5a);
    repeat (40) @(posedge mclk);
    rdc("frozen hi", tmr_pkg::cnt_high_off, 32'hff, 32'h0);
    rdc("frozen lo", tmr_pkg::cnt_low_off, 32'hff, 32'h0);
    dbg <= 1'b0;
  endtask
  // Edge PWM, divide by 128, match at 4: the output rises at the tick
  // from zero, and the flag waits for the match at the end of duty.
  task automatic t_edge_pwm();
    bus(1'b1, tmr_pkg::ctrl_off, 32'h0);
    bus(1'b1, tmr_pkg::modulo_off, 32'h10);
    bus(1'b1, 8'h24, 32'h4);
    bus(1'b1, 8'h20, 32'h8);
    bus(1'b1, tmr_pkg::cnt_low_off, 32'h0);
    clr();
    bus(1'b1, tmr_pkg::ctrl_off, 32'h17);
    repeat (200) @(posedge mclk);
    check("pwm high", {31'h0, pw[0]}, 32'h1);
    rdc("duty start", tmr_pkg::status_off, 32'h2, 32'h0);
    repeat (500) @(posedge mclk);
    check("pwm low", {31'h0, pw[0]}, 32'h0);
    rdc("duty end", tmr_pkg::status_off, 32'h2, 32'h2);
  endtask
  // Main sequence after a ten-cycle reset.
  initial begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_compare();
    t_capture();
    t_center();
    t_counter();
    t_edge_pwm();
    wrap_up();
  end
  // Watchdog, about four times the cycles the tests need.
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
endmodule // tb
